// ===== core/flag_hs_pkg.sv
// Shared constants, types and register layout of the two-wire handshake block
package flag_hs_pkg;

  // ===========================================================
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_STATUS   = 8'h04;
  localparam logic [7:0] OFS_DATA     = 8'h08;
  localparam logic [7:0] OFS_CPU      = 8'h0c;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;

  // ===========================================================
  // Field positions, reset values and response codes
  localparam int         CPU_GIE_BIT  = 7;
  localparam int         IRQ_DONE_BIT = 0;
  localparam int         IRQ_NACK_BIT = 1;
  localparam logic [7:0] DATA_RST     = 8'hff;
  localparam logic [1:0] RESP_OKAY    = 2'b00;
  localparam logic [1:0] RESP_SLVERR  = 2'b10;

  // ===========================================================
  // Status codes
  localparam logic [7:0] ST_START     = 8'h01;
  localparam logic [7:0] ST_ADDR_ACK  = 8'h02;
  localparam logic [7:0] ST_ADDR_NACK = 8'h03;
  localparam logic [7:0] ST_DATA_ACK  = 8'h04;
  localparam logic [7:0] ST_DATA_NACK = 8'h05;
  localparam logic [7:0] ST_NONE      = 8'hff;

  // ===========================================================
  // Timing
  localparam int CLK_NS      = 5;
  localparam int QUARTER_NS  = 2500;
  localparam int QUARTER_CYC = QUARTER_NS / CLK_NS;

  // ===========================================================
  // Types
  typedef enum logic [1:0] {CMD_START, CMD_BYTE, CMD_STOP} bus_cmd_t;

  typedef struct packed {
    logic done;
    logic rsv6;
    logic start;
    logic stop;
    logic rsv3;
    logic enable;
    logic rsv1;
    logic fie;
  } ctrl_t;

endpackage

// ===== core/wire_bit_engine.sv
// Bit-level sequencer for START, byte with acknowledge, and STOP
`timescale 1ns/1ps
module wire_bit_engine
  import flag_hs_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  // Step command
  input  wire logic       tick,
  input  wire logic       cmd_valid,
  input  wire bus_cmd_t   cmd,
  input  wire logic [7:0] tx_byte,
  // Synchronised bus levels
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  // Result
  output logic            busy,
  output logic            done,
  output logic            nack,
  // Line drivers, high pulls low
  output logic            scl_lo,
  output logic            sda_lo
);

  typedef enum logic [2:0] {E_IDLE, E_HOLD, E_START, E_BITS, E_STOP} eng_state_t;

  typedef struct packed {
    eng_state_t st;
    logic [1:0] q;
    logic [3:0] bitn;
    logic [8:0] sh;
    logic       nack;
    logic       done;
    logic       scl_lo;
    logic       sda_lo;
  } eng_regs_t;

  eng_regs_t r;
  eng_regs_t r_nxt;

  // ===========================================================
  // Sequencer
  always_comb begin
    r_nxt      = r;
    r_nxt.done = 1'b0;
    unique case (r.st)
      E_IDLE, E_HOLD: begin
        if (cmd_valid) begin
          r_nxt.q = 2'd0;
          unique case (cmd)
            CMD_START: r_nxt.st = E_START;
            CMD_STOP:  r_nxt.st = E_STOP;
            default: begin
              r_nxt.st   = E_BITS;
              r_nxt.sh   = {tx_byte, 1'b1};
              r_nxt.bitn = 4'd0;
            end
          endcase
        end
      end
      E_START: begin
        if (tick) begin
          unique case (r.q)
            2'd0: begin
              r_nxt.sda_lo = 1'b0;
              r_nxt.q      = 2'd1;
            end
            2'd1: begin
              r_nxt.scl_lo = 1'b0;
              if (scl_in) begin
                r_nxt.q = 2'd2;
              end
            end
            2'd2: begin
              r_nxt.sda_lo = 1'b1;
              r_nxt.q      = 2'd3;
            end
            default: begin
              r_nxt.scl_lo = 1'b1;
              r_nxt.st     = E_HOLD;
              r_nxt.done   = 1'b1;
            end
          endcase
        end
      end
      E_BITS: begin
        if (tick) begin
          unique case (r.q)
            2'd0: begin
              r_nxt.scl_lo = 1'b1;
              r_nxt.sda_lo = ~r.sh[8];
              r_nxt.q      = 2'd1;
            end
            2'd1: begin
              r_nxt.scl_lo = 1'b0;
              if (scl_in) begin
                r_nxt.q = 2'd2;
              end
            end
            2'd2: begin
              if (r.bitn == 4'd8) begin
                r_nxt.nack = sda_in;
              end
              r_nxt.q = 2'd3;
            end
            default: begin
              r_nxt.scl_lo = 1'b1;
              r_nxt.sh     = {r.sh[7:0], 1'b1};
              r_nxt.q      = 2'd0;
              if (r.bitn == 4'd8) begin
                r_nxt.st   = E_HOLD;
                r_nxt.done = 1'b1;
              end else begin
                r_nxt.bitn = r.bitn + 4'd1;
              end
            end
          endcase
        end
      end
      default: begin
        if (tick) begin
          unique case (r.q)
            2'd0: begin
              r_nxt.scl_lo = 1'b1;
              r_nxt.sda_lo = 1'b1;
              r_nxt.q      = 2'd1;
            end
            2'd1: begin
              r_nxt.scl_lo = 1'b0;
              if (scl_in) begin
                r_nxt.q = 2'd2;
              end
            end
            default: begin
              r_nxt.sda_lo = 1'b0;
              r_nxt.st     = E_IDLE;
            end
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      r <= '{st: E_IDLE, q: 2'd0, bitn: 4'd0, sh: 9'h1ff, nack: 1'b0,
             done: 1'b0, scl_lo: 1'b0, sda_lo: 1'b0};
    end else begin
      r <= r_nxt;
    end
  end

  assign busy   = (r.st == E_START) || (r.st == E_BITS) || (r.st == E_STOP);
  assign done   = r.done;
  assign nack   = r.nack;
  assign scl_lo = r.scl_lo;
  assign sda_lo = r.sda_lo;

endmodule

// ===== core/i2c_flag_handshake.sv
// Register front end, done flag, status and interrupt of the two-wire unit
`timescale 1ns/1ps
module i2c_flag_handshake
  import flag_hs_pkg::*;
#(
  parameter int QUARTER_CYCLES = QUARTER_CYC
)(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // AXI4-Lite write address and data
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // AXI4-Lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // AXI4-Lite read
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // Two-wire bus, open drain
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  // Interrupt
  output logic             irq
);

  typedef struct packed {
    logic        aw_got;
    logic [7:0]  aw_addr;
    logic        w_got;
    logic [31:0] w_data;
    logic        w_lane0;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        flag;
    ctrl_t       ctrl;
    logic [7:0]  status;
    logic [7:0]  code_pend;
    logic [7:0]  data;
    logic        gie;
    logic [1:0]  irq_stat;
    logic [1:0]  irq_mask;
    logic        addr_phase;
    bus_cmd_t    cmd;
    logic        launch;
    logic        scl_s1;
    logic        scl_s2;
    logic        sda_s1;
    logic        sda_s2;
    logic [15:0] div_cnt;
    logic        tick;
  } top_regs_t;

  top_regs_t r;
  top_regs_t r_nxt;

  logic eng_busy;
  logic eng_done;
  logic eng_nack;
  logic eng_scl_lo;
  logic eng_sda_lo;

  // ===========================================================
  // Bus sequencer
  wire_bit_engine u_engine (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .tick      (r.tick),
    .cmd_valid (r.launch),
    .cmd       (r.cmd),
    .tx_byte   (r.data),
    .scl_in    (r.scl_s2),
    .sda_in    (r.sda_s2),
    .busy      (eng_busy),
    .done      (eng_done),
    .nack      (eng_nack),
    .scl_lo    (eng_scl_lo),
    .sda_lo    (eng_sda_lo)
  );

  // ===========================================================
  // Next-state logic
  always_comb begin
    logic  wr_go;
    logic  clr;
    ctrl_t wc;
    r_nxt        = r;
    wr_go        = r.aw_got && r.w_got && !r.bvalid;
    clr          = 1'b0;
    wc           = ctrl_t'(r.w_data[7:0]);
    r_nxt.launch = 1'b0;

    // Pin synchronisers and quarter-bit divider
    r_nxt.scl_s1 = scl_i;
    r_nxt.scl_s2 = r.scl_s1;
    r_nxt.sda_s1 = sda_i;
    r_nxt.sda_s2 = r.sda_s1;
    r_nxt.tick   = 1'b0;
    if (r.div_cnt == 16'(QUARTER_CYCLES - 1)) begin
      r_nxt.div_cnt = 16'h0000;
      r_nxt.tick    = 1'b1;
    end else begin
      r_nxt.div_cnt = r.div_cnt + 16'h0001;
    end

    // Write channel capture
    if (s_axi_awvalid && s_axi_awready) begin
      r_nxt.aw_got  = 1'b1;
      r_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      r_nxt.w_got   = 1'b1;
      r_nxt.w_data  = s_axi_wdata;
      r_nxt.w_lane0 = s_axi_wstrb[0];
    end
    if (r.bvalid && s_axi_bready) begin
      r_nxt.bvalid = 1'b0;
    end

    // Register writes
    if (wr_go) begin
      r_nxt.aw_got = 1'b0;
      r_nxt.w_got  = 1'b0;
      r_nxt.bvalid = 1'b1;
      r_nxt.bresp  = RESP_OKAY;
      unique case (r.aw_addr)
        OFS_CTRL: begin
          if (r.w_lane0) begin
            r_nxt.ctrl      = wc;
            r_nxt.ctrl.done = 1'b0;
            r_nxt.ctrl.rsv6 = 1'b0;
            r_nxt.ctrl.rsv3 = 1'b0;
            r_nxt.ctrl.rsv1 = 1'b0;
            clr             = wc.done;
            if (wc.done && wc.enable && !eng_busy) begin
              r_nxt.launch = 1'b1;
              if (wc.start) begin
                r_nxt.cmd        = CMD_START;
                r_nxt.addr_phase = 1'b1;
              end else if (wc.stop) begin
                r_nxt.cmd = CMD_STOP;
              end else begin
                r_nxt.cmd = CMD_BYTE;
              end
            end
          end
        end
        OFS_DATA: begin
          if (r.w_lane0) begin
            r_nxt.data = r.w_data[7:0];
          end
        end
        OFS_CPU: begin
          if (r.w_lane0) begin
            r_nxt.gie = r.w_data[CPU_GIE_BIT];
          end
        end
        OFS_IRQ_STAT: begin
          if (r.w_lane0) begin
            r_nxt.irq_stat = r.irq_stat & ~r.w_data[1:0];
          end
        end
        OFS_IRQ_MASK: begin
          if (r.w_lane0) begin
            r_nxt.irq_mask = r.w_data[1:0];
          end
        end
        OFS_STATUS: begin
        end
        default: begin
          r_nxt.bresp = RESP_SLVERR;
        end
      endcase
    end

    // Done flag, status code and event bits; a set wins over a clear
    r_nxt.flag = (r.flag && !clr) || eng_done;
    if (eng_done) begin
      unique case (r.cmd)
        CMD_START: r_nxt.code_pend = ST_START;
        CMD_BYTE: begin
          if (r.addr_phase) begin
            r_nxt.code_pend = eng_nack ? ST_ADDR_NACK : ST_ADDR_ACK;
          end else begin
            r_nxt.code_pend = eng_nack ? ST_DATA_NACK : ST_DATA_ACK;
          end
          r_nxt.addr_phase = 1'b0;
        end
        default: begin
        end
      endcase
      r_nxt.irq_stat[IRQ_DONE_BIT] = 1'b1;
      r_nxt.irq_stat[IRQ_NACK_BIT] = r_nxt.irq_stat[IRQ_NACK_BIT] ||
                                     (eng_nack && (r.cmd == CMD_BYTE));
    end
    r_nxt.status = r.flag ? r.code_pend : ST_NONE;

    // Register reads
    if (r.rvalid && s_axi_rready) begin
      r_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      r_nxt.rvalid = 1'b1;
      r_nxt.rdata  = 32'h0000_0000;
      r_nxt.rresp  = RESP_OKAY;
      unique case (s_axi_araddr)
        OFS_CTRL: begin
          r_nxt.rdata[7:0] = {r.flag, r.ctrl[6:0]};
        end
        OFS_STATUS:   r_nxt.rdata[7:0] = r.status;
        OFS_DATA:     r_nxt.rdata[7:0] = r.data;
        OFS_CPU:      r_nxt.rdata[CPU_GIE_BIT] = r.gie;
        OFS_IRQ_STAT: r_nxt.rdata[1:0] = r.irq_stat;
        OFS_IRQ_MASK: r_nxt.rdata[1:0] = r.irq_mask;
        default:      r_nxt.rresp = RESP_SLVERR;
      endcase
    end
  end

  // ===========================================================
  // State register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      r <= '{aw_got: 1'b0, aw_addr: 8'h00, w_got: 1'b0, w_data: 32'h0000_0000,
             w_lane0: 1'b0, bvalid: 1'b0, bresp: RESP_OKAY, rvalid: 1'b0,
             rdata: 32'h0000_0000, rresp: RESP_OKAY, flag: 1'b0, ctrl: '0,
             status: ST_NONE, code_pend: ST_NONE, data: DATA_RST, gie: 1'b0,
             irq_stat: 2'b00, irq_mask: 2'b00, addr_phase: 1'b0,
             cmd: CMD_START, launch: 1'b0, scl_s1: 1'b1, scl_s2: 1'b1,
             sda_s1: 1'b1, sda_s2: 1'b1, div_cnt: 16'h0000, tick: 1'b0};
    end else begin
      r <= r_nxt;
    end
  end

  // ===========================================================
  // Outputs
  assign s_axi_awready = !r.aw_got && !r.bvalid;
  assign s_axi_wready  = !r.w_got && !r.bvalid;
  assign s_axi_bvalid  = r.bvalid;
  assign s_axi_bresp   = r.bresp;
  assign s_axi_arready = !r.rvalid;
  assign s_axi_rvalid  = r.rvalid;
  assign s_axi_rdata   = r.rdata;
  assign s_axi_rresp   = r.rresp;
  assign scl_o         = 1'b0;
  assign scl_oe        = eng_scl_lo;
  assign sda_o         = 1'b0;
  assign sda_oe        = eng_sda_lo;
  assign irq = r.gie && ((r.flag && r.ctrl.fie) ||
                         (|(r.irq_stat & r.irq_mask)));

endmodule

// ===== tb/flag_hs_asserts.sv
// Port-level checks of the two-wire handshake block
`timescale 1ns/1ps
module flag_hs_asserts
  import flag_hs_pkg::*;
#(
  parameter int QUARTER_CYCLES = 4
)(
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        rst_n,
  // Register writes
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_bvalid,
  // Bus and interrupt
  input wire logic        scl_oe,
  input wire logic        sda_oe,
  input wire logic        irq
);
  // ==========================================
  // Shadow of register writes
  localparam int START_MAX = 16 * QUARTER_CYCLES + 8;
  localparam int OP_MAX    = 40 * QUARTER_CYCLES + 16;
  logic [7:0]  aa, wd, dq;
  logic [1:0]  mq;
  logic [15:0] since;
  logic        bv_d, gq, fq, bp, wr, go;
  assign wr = s_axi_bvalid && !bv_d;
  assign go = wr && aa == OFS_CTRL && wd[7] && wd[2];
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      {aa, wd, dq, mq, bv_d, gq, fq, bp} <= '0;
      since <= 16'hffff;
    end else begin
      bv_d  <= s_axi_bvalid;
      since <= go ? 16'h0 : since + {15'h0, since != 16'hffff};
      if (s_axi_awvalid && s_axi_awready) aa <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) wd <= s_axi_wdata[7:0];
      if (wr && aa == OFS_CPU) gq <= wd[CPU_GIE_BIT];
      if (wr && aa == OFS_CTRL) fq <= wd[0];
      if (wr && aa == OFS_IRQ_MASK) mq <= wd[1:0];
      if (wr && aa == OFS_DATA) dq <= wd;
      if (go && wd[5:4] == 2'h0) bp <= 1'h1;
      else if (!scl_oe) bp <= 1'h0;
    end
  end
  // ==========================================
  // Assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence go_start_s;
    go && wd[5] && !scl_oe && !sda_oe;
  endsequence
  sequence go_stop_s;
    go && !wd[5] && wd[4] && wd[0] && gq && mq == 2'h0;
  endsequence
  a_irq_enables: assert property (irq && !wr |-> gq && (fq || mq != 2'h0))
    else $error("irq without enables");
  a_start_begins: assert property (go_start_s |-> ##[1:START_MAX] (sda_oe && !scl_oe))
    else $error("start not begun");
  a_start_asked: assert property ($rose(sda_oe) && !scl_oe |-> since < START_MAX)
    else $error("start without launch");
  a_scl_held: assert property ($fell(scl_oe) |-> since < OP_MAX)
    else $error("clock released while flagged");
  a_msb_first: assert property (bp && $fell(scl_oe) |-> sda_oe == !dq[7])
    else $error("first bit wrong");
  a_event_flag: assert property (go && !wd[4] && wd[0] && gq |-> ##[1:OP_MAX] irq)
    else $error("no flag after event");
  a_stop_quiet: assert property (go_stop_s |-> (!irq throughout (##OP_MAX 1)))
    else $error("flag after stop");
  a_done_clears: assert property (wr && aa == OFS_CTRL && wd[7] && mq == 2'h0 |-> !irq)
    else $error("flag not cleared");
  a_zero_keeps: assert property (wr && aa == OFS_CTRL && !wd[7] && wd[0] && gq && $past(irq)
    |-> irq)
    else $error("flag lost");
endmodule
bind i2c_flag_handshake flag_hs_asserts #(.QUARTER_CYCLES(QUARTER_CYCLES)) chk_u (
  .clk_sys, .rst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
  .s_axi_wready, .s_axi_wdata, .s_axi_bvalid, .scl_oe, .sda_oe, .irq);

// ===== tb/i2c_slave_model.sv
// Behavioural two-wire slave that acknowledges and captures bytes
`timescale 1ns/1ps
module i2c_slave_model (
  // Resolved lines
  input wire logic        scl,
  input wire logic        sda,
  // Answer select, high refuses
  input wire logic        nack_mode,
  // Outputs
  output logic            sda_pull,
  output logic [7:0]      rx_byte,
  output logic [7:0]      n_stop
);
  logic [3:0] cnt = 4'h0;
  initial sda_pull = 1'h0;
  initial rx_byte = 8'h00;
  initial n_stop = 8'h00;
  always @(negedge sda) if (scl) cnt = 4'h0;
  always @(posedge sda) if (scl) n_stop = n_stop + 8'h01;
  always @(posedge scl) begin
    if (cnt != 4'h8) rx_byte = {rx_byte[6:0], sda};
    cnt = (cnt == 4'h9) ? 4'h1 : cnt + 4'h1;
  end
  always @(negedge scl) sda_pull = (cnt == 4'h8) && !nack_mode;
endmodule

// ===== tb/tb_top.sv
// Self-checking bench for the two-wire handshake block
`timescale 1ns/1ps
module tb_top
  import flag_hs_pkg::*;
;
  logic        clk_sys = '0, rst_n = '0, nack_mode = '0;
  logic        s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_arvalid = '0;
  logic        s_axi_bready = 1'h1, s_axi_rready = 1'h1;
  logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0, rx_byte, n_stop;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        scl_o, scl_oe, sda_o, sda_oe, irq, sda_pull, scl_i, sda_i;
  int          n_fail = 0, total_checks = 0;
  assign scl_i = scl_oe ? scl_o : 1'h1;
  assign sda_i = (sda_oe ? sda_o : 1'h1) & !sda_pull;
  initial forever #2.5 clk_sys = !clk_sys;
  i2c_flag_handshake #(.QUARTER_CYCLES(4)) dut_u (
    .clk_sys, .rst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
    .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp, .scl_i, .scl_o, .scl_oe, .sda_i, .sda_o, .sda_oe, .irq);
  i2c_slave_model slv_u (.scl(scl_i), .sda(sda_i), .nack_mode, .sda_pull, .rx_byte, .n_stop);
  // ==========================================
  // Shared tasks
  task automatic results();
    if (n_fail == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic hang();
    check("wait bound", 32'h0, 32'h1);
    results();
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    for (n = 0; n < 64; n++) begin
      @(posedge clk_sys);
      if (s_axi_bvalid) break;
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end
    if (n == 64) hang();
    r = s_axi_bresp;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    for (n = 0; n < 64; n++) begin
      @(posedge clk_sys);
      if (s_axi_rvalid) break;
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end
    if (n == 64) hang();
    d = s_axi_rdata;
  endtask
  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    check(nm, d, e);
  endtask
  task automatic poll();
    int n;
    logic [31:0] d;
    for (n = 0; n < 400; n++) begin
      rd(OFS_CTRL, d);
      if (d[7] === 1'h1) break;
    end
    if (n == 400) hang();
  endtask
  // ==========================================
  // Scenarios
  task automatic t_regs();
    logic [1:0] r;
    logic [7:0] a[6] = '{OFS_CTRL, OFS_STATUS, OFS_DATA, OFS_CPU, OFS_IRQ_STAT, OFS_IRQ_MASK};
    logic [7:0] e[6] = '{8'h00, ST_NONE, DATA_RST, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 6; i++) rc("reset value", a[i], {24'h0, e[i]});
    rc("unmapped read", 8'h40, 32'h0);
    check("unmapped rresp", s_axi_rresp, RESP_SLVERR);
    wr(8'h40, 8'h5a, r);
    check("unmapped bresp", r, RESP_SLVERR);
    wr(OFS_CTRL, 8'h24, r);
    repeat (100) @(posedge clk_sys);
    check("idle lines", {scl_oe, sda_oe}, 2'h0);
  endtask
  task automatic t_xfer(input logic nk, input logic [7:0] ad, input logic [7:0] db);
    logic [1:0]  r;
    logic [31:0] d;
    logic [7:0]  ns;
    ns = n_stop;
    nack_mode <= nk;
    wr(OFS_CTRL, 8'ha4, r);
    poll();
    rc("start code", OFS_STATUS, ST_START);
    check("clock held", scl_oe, 1'h1);
    wr(OFS_DATA, ad, r);
    wr(OFS_CTRL, 8'h84, r);
    rc("status none", OFS_STATUS, ST_NONE);
    poll();
    check("address bits", rx_byte, ad);
    rc("address code", OFS_STATUS, nk ? ST_ADDR_NACK : ST_ADDR_ACK);
    wr(OFS_DATA, db, r);
    wr(OFS_CTRL, 8'h24, r);
    rc("flag kept", OFS_CTRL, 32'ha4);
    wr(OFS_CTRL, 8'h84, r);
    poll();
    check("data bits", rx_byte, db);
    rc("data code", OFS_STATUS, nk ? ST_DATA_NACK : ST_DATA_ACK);
    wr(OFS_CTRL, 8'h94, r);
    repeat (200) @(posedge clk_sys);
    rd(OFS_CTRL, d);
    check("flag after stop", d[7], 1'h0);
    check("stop seen", n_stop, ns + 8'h01);
  endtask
  task automatic t_irq();
    logic [1:0] r;
    int         n;
    wr(OFS_CPU, 8'h80, r);
    wr(OFS_CTRL, 8'ha5, r);
    for (n = 0; n < 400 && irq !== 1'h1; n++) @(posedge clk_sys);
    if (n == 400) hang();
    wr(OFS_CTRL, 8'h25, r);
    check("irq kept", irq, 1'h1);
    wr(OFS_CPU, 8'h00, r);
    check("irq global off", irq, 1'h0);
    wr(OFS_CPU, 8'h80, r);
    check("irq global on", irq, 1'h1);
    wr(OFS_CTRL, 8'h80, r);
    check("irq flag cleared", irq, 1'h0);
    rc("event bits", OFS_IRQ_STAT, 32'h3);
    wr(OFS_IRQ_MASK, 8'h01, r);
    check("masked event", irq, 1'h1);
    wr(OFS_IRQ_STAT, 8'h03, r);
    check("event cleared", irq, 1'h0);
    wr(OFS_IRQ_MASK, 8'h00, r);
    wr(OFS_CTRL, 8'h95, r);
    repeat (200) @(posedge clk_sys);
    check("irq after stop", irq, 1'h0);
  endtask
  initial begin
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'h1;
    @(posedge clk_sys);
    t_regs();
    t_xfer(1'h0, 8'h42, 8'h5a);
    t_xfer(1'h1, 8'hc2, 8'ha5);
    t_irq();
    results();
  end
endmodule
